//--- design/ieb_pkg.sv
// Purpose: Constants for the interrupt enable bank.
// Assumes: Five 16-bit enable registers on a plain register port.
// Notes: Offsets are word indices on the register port.
package ieb_pkg;
  localparam int IEB_AW = 3;
  localparam int IEB_DW = 16;
  localparam logic [2:0] IEB_OFF_BANK1 = 3'h0;
  localparam logic [2:0] IEB_OFF_BANK2 = 3'h1;
  localparam logic [2:0] IEB_OFF_BANK3 = 3'h2;
  localparam logic [2:0] IEB_OFF_BANK4 = 3'h3;
  localparam logic [2:0] IEB_OFF_BANK5 = 3'h4;
  localparam logic [15:0] IEB_RESET = 16'h0000;
  // Implemented-bit masks; zeros mark positions that read zero and ignore writes.
  localparam logic [15:0] IEB_MASK1 = 16'hfedf;
  localparam logic [15:0] IEB_MASK2 = 16'h3fe3;
  localparam logic [15:0] IEB_MASK3 = 16'h4066;
  localparam logic [15:0] IEB_MASK4 = 16'h210e;
  localparam logic [15:0] IEB_MASK5 = 16'h3fbe;
  // Field positions used to name individual gates.
  localparam int IEB_B1_UART2_TX = 15;
  localparam int IEB_B1_EXT2 = 13;
  localparam int IEB_B1_EXT1 = 4;
  localparam int IEB_B3_CALENDAR = 14;
  localparam int IEB_B3_EXT4 = 6;
  localparam int IEB_B3_EXT3 = 5;
  localparam int IEB_B4_CHARGE = 13;
  localparam int IEB_B4_LOW_VOLT = 8;
  localparam int IEB_B4_CHECKSUM = 3;
endpackage : ieb_pkg

//--- design/ieb_reg.sv
// Purpose: One masked enable register of the bank.
// Assumes: Write strobe is one cycle, same clock domain.
// Notes: Unimplemented bits are never stored, so they always read zero.
`timescale 1ns/1ps
module ieb_reg #(
  parameter logic [15:0] MASK = 16'hffff
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Write side
  input wire logic load,
  input wire logic [15:0] wdata,
  // Stored value
  output logic [15:0] value
);
  import ieb_pkg::*;

  typedef struct packed {
    logic [15:0] value;
  } ieb_reg_s;

  ieb_reg_s state;
  ieb_reg_s next_state;

  always_comb begin
    next_state = state;
    if (load) begin
      next_state.value = wdata & MASK;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= '{value: IEB_RESET};
    end else begin
      state <= next_state;
    end
  end

  assign value = state.value;
endmodule : ieb_reg

//--- design/ieb_bank.sv
// Purpose: Bank of five interrupt enable registers gating pending requests.
// Assumes: Single clock; register port is a same-domain master.
// Notes: Flags and priorities live elsewhere; this block only gates requests.
//
// Summary of operation
// - Enable one passes request, zero blocks it
// - Bank 1 high byte: uart2, pin2, timers
// - Bank 1 low byte: captures, pin1, misc
// - Bank 2: parallel, compares, captures, spi2
// - Bank 3: calendar, pins 3-4, i2c2
// - Bank 4: charge, low voltage, checksum, uart errors
// - Bank 5: capture9, compare9, spi3, uart3-4, i2c3
`timescale 1ns/1ps
module ieb_bank (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // Register port
  input wire logic [ieb_pkg::IEB_AW-1:0] addr,
  input wire logic [ieb_pkg::IEB_DW-1:0] wdata,
  input wire logic write,
  input wire logic read,
  output logic [ieb_pkg::IEB_DW-1:0] rdata,
  // Pending flags from the flag registers, one word per bank
  input wire logic [15:0] flags1,
  input wire logic [15:0] flags2,
  input wire logic [15:0] flags3,
  input wire logic [15:0] flags4,
  input wire logic [15:0] flags5,
  // Requests passed on to arbitration
  output logic [15:0] request1,
  output logic [15:0] request2,
  output logic [15:0] request3,
  output logic [15:0] request4,
  output logic [15:0] request5,
  // Named gates that other logic watches directly
  output logic ext_pin1_gate,
  output logic ext_pin2_gate,
  output logic ext_pin3_gate,
  output logic ext_pin4_gate,
  output logic calendar_gate,
  output logic low_voltage_gate,
  output logic checksum_gen_gate,
  output logic charge_timer_gate
);
  import ieb_pkg::*;

  typedef struct packed {
    logic [15:0] rdata;
  } ieb_bank_s;

  ieb_bank_s state;
  ieb_bank_s next_state;
  logic [15:0] bank1;
  logic [15:0] bank2;
  logic [15:0] bank3;
  logic [15:0] bank4;
  logic [15:0] bank5;

  function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
    hit = (a == off);
  endfunction : hit

  // Bank 1 high byte bit 8 and low byte bit 5 are holes in the mask.
  ieb_reg #(.MASK(IEB_MASK1)) u_bank1 (
    .clock(clock),
    .resetn(resetn),
    .load(write && hit(addr, IEB_OFF_BANK1)),
    .wdata(wdata),
    .value(bank1)
  );
  ieb_reg #(.MASK(IEB_MASK2)) u_bank2 (
    .clock(clock),
    .resetn(resetn),
    .load(write && hit(addr, IEB_OFF_BANK2)),
    .wdata(wdata),
    .value(bank2)
  );
  ieb_reg #(.MASK(IEB_MASK3)) u_bank3 (
    .clock(clock),
    .resetn(resetn),
    .load(write && hit(addr, IEB_OFF_BANK3)),
    .wdata(wdata),
    .value(bank3)
  );
  ieb_reg #(.MASK(IEB_MASK4)) u_bank4 (
    .clock(clock),
    .resetn(resetn),
    .load(write && hit(addr, IEB_OFF_BANK4)),
    .wdata(wdata),
    .value(bank4)
  );
  ieb_reg #(.MASK(IEB_MASK5)) u_bank5 (
    .clock(clock),
    .resetn(resetn),
    .load(write && hit(addr, IEB_OFF_BANK5)),
    .wdata(wdata),
    .value(bank5)
  );

  // Read data is registered so it stands only in the cycle after the strobe.
  always_comb begin
    next_state.rdata = 16'h0000;
    if (read) begin
      case (addr)
        IEB_OFF_BANK1: next_state.rdata = bank1;
        IEB_OFF_BANK2: next_state.rdata = bank2;
        IEB_OFF_BANK3: next_state.rdata = bank3;
        IEB_OFF_BANK4: next_state.rdata = bank4;
        IEB_OFF_BANK5: next_state.rdata = bank5;
        default: next_state.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= '{rdata: 16'h0000};
    end else begin
      state <= next_state;
    end
  end

  assign rdata = state.rdata;

  // A flag with its enable clear never reaches arbitration.
  assign request1 = flags1 & bank1;
  assign request2 = flags2 & bank2;
  assign request3 = flags3 & bank3;
  assign request4 = flags4 & bank4;
  assign request5 = flags5 & bank5;

  // Enabling a pin gate is useless unless software also routes the pin.
  assign ext_pin1_gate = bank1[IEB_B1_EXT1];
  assign ext_pin2_gate = bank1[IEB_B1_EXT2];
  assign ext_pin3_gate = bank3[IEB_B3_EXT3];
  assign ext_pin4_gate = bank3[IEB_B3_EXT4];
  assign calendar_gate = bank3[IEB_B3_CALENDAR];
  assign low_voltage_gate = bank4[IEB_B4_LOW_VOLT];
  assign checksum_gen_gate = bank4[IEB_B4_CHECKSUM];
  assign charge_timer_gate = bank4[IEB_B4_CHARGE];

  AST_REQ_GATED: assert property (@(posedge clock) disable iff (!resetn)
    ((request1 & ~(flags1 & IEB_MASK1)) == 16'h0000)
    && ((request2 & ~(flags2 & IEB_MASK2)) == 16'h0000)
    && ((request3 & ~(flags3 & IEB_MASK3)) == 16'h0000)
    && ((request4 & ~(flags4 & IEB_MASK4)) == 16'h0000)
    && ((request5 & ~(flags5 & IEB_MASK5)) == 16'h0000))
    else $error("Request passed without its flag or an implemented enable.");

  AST_READ_BACK: assert property (@(posedge clock) disable iff (!resetn)
    (write && hit(addr, IEB_OFF_BANK2)) ##1 (read && hit(addr, IEB_OFF_BANK2))
    |=> rdata == (($past(wdata, 2)) & IEB_MASK2))
    else $error("Bank 2 read-back differs from masked write.");

  AST_HOLES1: assert property (@(posedge clock) disable iff (!resetn)
    (bank1 & ~IEB_MASK1) == 16'h0000)
    else $error("Bank 1 hole bit set.");

  AST_HOLES3: assert property (@(posedge clock) disable iff (!resetn)
    (bank3 & ~IEB_MASK3) == 16'h0000)
    else $error("Bank 3 hole bit set.");

  AST_HOLES4: assert property (@(posedge clock) disable iff (!resetn)
    (bank4 & ~IEB_MASK4) == 16'h0000)
    else $error("Bank 4 hole bit set.");

  AST_HOLES5: assert property (@(posedge clock) disable iff (!resetn)
    (bank5 & ~IEB_MASK5) == 16'h0000)
    else $error("Bank 5 hole bit set.");

  AST_WRITE2: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK2) |=> bank2 == ($past(wdata) & IEB_MASK2))
    else $error("Bank 2 did not take write.");

  AST_HOLD1: assert property (@(posedge clock) disable iff (!resetn)
    !(write && hit(addr, IEB_OFF_BANK1)) |=> $stable(bank1))
    else $error("Bank 1 changed without a write.");

  AST_IDLE_READ: assert property (@(posedge clock) disable iff (!resetn)
    !read |=> rdata == 16'h0000)
    else $error("Read data without a read strobe.");

  // Per-bank checks tie banks, requests and gates back to the write that set them; read data are checked against the register.
  AST_HOLES2: assert property (@(posedge clock) disable iff (!resetn)
    (bank2 & ~IEB_MASK2) == 16'h0000)
    else $error("Bank 2 hole bit set.");

  AST_WRITE1: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK1)
    |=> bank1 == ($past(wdata) & IEB_MASK1))
    else $error("Bank 1 did not take write.");

  AST_WRITE3: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK3)
    |=> bank3 == ($past(wdata) & IEB_MASK3))
    else $error("Bank 3 did not take write.");

  AST_WRITE4: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK4)
    |=> bank4 == ($past(wdata) & IEB_MASK4))
    else $error("Bank 4 did not take write.");

  AST_WRITE5: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK5)
    |=> bank5 == ($past(wdata) & IEB_MASK5))
    else $error("Bank 5 did not take write.");

  AST_HOLD2: assert property (@(posedge clock) disable iff (!resetn)
    !(write && hit(addr, IEB_OFF_BANK2)) |=> $stable(bank2))
    else $error("Bank 2 changed without a write.");

  AST_HOLD3: assert property (@(posedge clock) disable iff (!resetn)
    !(write && hit(addr, IEB_OFF_BANK3)) |=> $stable(bank3))
    else $error("Bank 3 changed without a write.");

  AST_HOLD4: assert property (@(posedge clock) disable iff (!resetn)
    !(write && hit(addr, IEB_OFF_BANK4)) |=> $stable(bank4))
    else $error("Bank 4 changed without a write.");

  AST_HOLD5: assert property (@(posedge clock) disable iff (!resetn)
    !(write && hit(addr, IEB_OFF_BANK5)) |=> $stable(bank5))
    else $error("Bank 5 changed without a write.");

  AST_READ1: assert property (@(posedge clock) disable iff (!resetn)
    read && hit(addr, IEB_OFF_BANK1)
    |=> rdata == $past(bank1))
    else $error("Bank 1 read data differ from the register.");

  AST_READ2: assert property (@(posedge clock) disable iff (!resetn)
    read && hit(addr, IEB_OFF_BANK2)
    |=> rdata == $past(bank2))
    else $error("Bank 2 read data differ from the register.");

  AST_READ3: assert property (@(posedge clock) disable iff (!resetn)
    read && hit(addr, IEB_OFF_BANK3)
    |=> rdata == $past(bank3))
    else $error("Bank 3 read data differ from the register.");

  AST_READ4: assert property (@(posedge clock) disable iff (!resetn)
    read && hit(addr, IEB_OFF_BANK4)
    |=> rdata == $past(bank4))
    else $error("Bank 4 read data differ from the register.");

  AST_READ5: assert property (@(posedge clock) disable iff (!resetn)
    read && hit(addr, IEB_OFF_BANK5)
    |=> rdata == $past(bank5))
    else $error("Bank 5 read data differ from the register.");

  AST_REQ_WRITE1: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK1)
    |=> request1 == (flags1 & $past(wdata) & IEB_MASK1))
    else $error("Bank 1 requests do not follow the written enables.");

  AST_REQ_WRITE2: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK2)
    |=> request2 == (flags2 & $past(wdata) & IEB_MASK2))
    else $error("Bank 2 requests do not follow the written enables.");

  AST_REQ_WRITE3: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK3)
    |=> request3 == (flags3 & $past(wdata) & IEB_MASK3))
    else $error("Bank 3 requests do not follow the written enables.");

  AST_REQ_WRITE4: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK4)
    |=> request4 == (flags4 & $past(wdata) & IEB_MASK4))
    else $error("Bank 4 requests do not follow the written enables.");

  AST_REQ_WRITE5: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK5)
    |=> request5 == (flags5 & $past(wdata) & IEB_MASK5))
    else $error("Bank 5 requests do not follow the written enables.");

  AST_GATES_B1: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK1)
    |=> (ext_pin1_gate == $past(wdata[IEB_B1_EXT1]))
    && (ext_pin2_gate == $past(wdata[IEB_B1_EXT2])))
    else $error("Bank 1 pin gates do not follow the write.");

  AST_GATES_B3: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK3)
    |=> (ext_pin3_gate == $past(wdata[IEB_B3_EXT3]))
    && (ext_pin4_gate == $past(wdata[IEB_B3_EXT4]))
    && (calendar_gate == $past(wdata[IEB_B3_CALENDAR])))
    else $error("Bank 3 gates do not follow the write.");

  AST_GATES_B4: assert property (@(posedge clock) disable iff (!resetn)
    write && hit(addr, IEB_OFF_BANK4)
    |=> (low_voltage_gate == $past(wdata[IEB_B4_LOW_VOLT]))
    && (checksum_gen_gate == $past(wdata[IEB_B4_CHECKSUM]))
    && (charge_timer_gate == $past(wdata[IEB_B4_CHARGE])))
    else $error("Bank 4 gates do not follow the write.");

  AST_REFUSED_WRITE: assert property (@(posedge clock) disable iff (!resetn)
    write && (addr > IEB_OFF_BANK5)
    |=> $stable(bank1) && $stable(bank2) && $stable(bank3)
    && $stable(bank4) && $stable(bank5))
    else $error("Write to an unused index changed a bank.");

  AST_READ_UNUSED: assert property (@(posedge clock) disable iff (!resetn)
    read && (addr > IEB_OFF_BANK5) |=> rdata == 16'h0000)
    else $error("Read of an unused index returned data.");
endmodule : ieb_bank

//--- tb/ieb_tb.sv
// Purpose: Self-checking bench for the interrupt enable bank.
// Assumes: Register port with one-cycle strobes and read data one cycle later.
// Notes: Each access except the write in wr_rd is followed by an idle cycle, so no strobe is assigned twice in a step.
`timescale 1ns/1ps
module testbench;
  import ieb_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic write = 1'b0;
  logic read = 1'b0;
  logic [15:0] flags [5] = '{default: 16'h0000};
  wire logic [15:0] rdata;
  wire logic [15:0] request [5];
  wire logic [7:0] gates;
  // Implemented positions, written out from the bit layouts of the five registers.
  logic [15:0] impl [5] = '{16'hfedf, 16'h3fe3, 16'h4066, 16'h210e, 16'h3fbe};
  int err_count = 0;
  int compares = 0;
  int i;
  always #50 clock = ~clock;
  ieb_bank dut_u (.clock(clock), .resetn(resetn), .addr(addr), .wdata(wdata), .write(write),
    .read(read), .rdata(rdata), .flags1(flags[0]), .flags2(flags[1]), .flags3(flags[2]),
    .flags4(flags[3]), .flags5(flags[4]), .request1(request[0]), .request2(request[1]),
    .request3(request[2]), .request4(request[3]), .request5(request[4]),
    .ext_pin1_gate(gates[0]), .ext_pin2_gate(gates[1]), .ext_pin3_gate(gates[2]),
    .ext_pin4_gate(gates[3]), .calendar_gate(gates[4]), .low_voltage_gate(gates[5]),
    .checksum_gen_gate(gates[6]), .charge_timer_gate(gates[7]));
  task automatic check16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check16
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clock);
    write <= 1'b0;
    @(posedge clock);
  endtask : wr
  // Read data stand only in the cycle after the strobe, and read zero after that.
  task automatic rd(input logic [2:0] a, input logic [15:0] exp);
    addr <= a;
    read <= 1'b1;
    @(posedge clock);
    read <= 1'b0;
    #1 check16(rdata, exp);
    @(posedge clock);
    #1 check16(rdata, 16'h0000);
    @(posedge clock);
  endtask : rd
  // Write then read with no gap between the strobes; the read must see the new value.
  task automatic wr_rd(input logic [2:0] a, input logic [15:0] d, input logic [15:0] exp);
    addr <= a;
    wdata <= d;
    write <= 1'b1;
    @(posedge clock);
    write <= 1'b0;
    read <= 1'b1;
    @(posedge clock);
    read <= 1'b0;
    #1 check16(rdata, exp);
    @(posedge clock);
    #1 check16(rdata, 16'h0000);
    @(posedge clock);
  endtask : wr_rd
  task automatic req_check(input logic [15:0] f, input logic on);
    for (int k = 0; k < 5; k++) flags[k] <= f;
    @(posedge clock);
    #1;
    for (int k = 0; k < 5; k++) check16(request[k], f & (on ? impl[k] : 16'h0000));
    @(posedge clock);
  endtask : req_check
  task automatic complete_run;
    $display("err_count %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  initial begin
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    for (i = 0; i < 5; i++) rd(i[2:0], 16'h0000);
    req_check(16'hffff, 1'b0);
    check16({8'h00, gates}, 16'h0000);
    for (i = 0; i < 5; i++) begin
      wr(i[2:0], 16'hffff);
      rd(i[2:0], impl[i]);
    end
    req_check(16'hffff, 1'b1);
    req_check(16'ha5a5, 1'b1);
    check16({8'h00, gates}, 16'h00ff);
    // Pin gates 1-3 are set and pin 4 cleared here; routing those pins is software's job outside this block.
    wr(3'h0, 16'h2010);
    wr(3'h2, 16'h0020);
    wr(3'h3, 16'h0108);
    check16({8'h00, gates}, 16'h0067);
    rd(3'h0, 16'h2010);
    wr(3'h4, 16'hc041);
    rd(3'h4, 16'h0000);
    wr(3'h5, 16'hffff);
    rd(3'h5, 16'h0000);
    rd(3'h1, impl[1]);
    wr_rd(3'h1, 16'h5a5a, 16'h1a42);
    wr_rd(3'h4, 16'hffff, 16'h3fbe);
    resetn <= 1'b0;
    @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd(3'h1, 16'h0000);
    check16({8'h00, gates}, 16'h0000);
    req_check(16'hffff, 1'b0);
    complete_run();
  end
  initial begin
    repeat (2000) @(posedge clock);
    err_count++;
    complete_run();
  end
endmodule : testbench
